// File: drs_delay_timer.sv
// restartable delay counter: done rises after run held for CYCLES edges
`timescale 1ns/1ps
module drs_delay_timer #(
    parameter int CYCLES = 80000
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic run,
    output logic done
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_r;
    logic done_r;

    ////////////////////////////////////////////////////////////////////////
    // restart on loss
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cnt_r <= '0;
            done_r <= 1'b0;
        end else if (!run) begin
            cnt_r <= '0;
            done_r <= 1'b0;
        end else if (!done_r) begin
            if (cnt_r == LAST) begin
                done_r <= 1'b1;
            end else begin
                cnt_r <= cnt_r + CW'(1);
            end
        end
    end

    assign done = done_r;
endmodule // drs_delay_timer

// File: drs_host_model.sv
// host model: bit-level i2c master for the enable register
`timescale 1ns/1ps
module drs_host_model (
    input wire logic mclk,
    input wire logic sda_wire,
    output logic scl,
    output logic sda_low
);
    import drs_pkg::*;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // sda moves only mid-low, so the synced scl never sees a false stop
    task automatic bit_io(input logic b, output logic s);
        sda_low = !b;
        hold(6);
        scl = 1'b1;
        hold(3);
        s = sda_wire;
        hold(3);
        scl = 1'b0;
        hold(6);
    endtask
    task automatic byte_io(input logic [7:0] v, output logic [7:0] s,
                           output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_io(v[i], s[i]);
        end
        bit_io(1'b1, a);
    endtask
    task automatic start();
        sda_low = 1'b0;
        hold(6);
        scl = 1'b1;
        hold(6);
        sda_low = 1'b1;
        hold(6);
        scl = 1'b0;
        hold(6);
    endtask
    task automatic stop();
        sda_low = 1'b1;
        hold(6);
        scl = 1'b1;
        hold(6);
        sda_low = 1'b0;
        hold(6);
    endtask
    task automatic write(input logic [6:0] adr, input logic [7:0] ofs,
                         input logic [7:0] d, input logic do_stop,
                         output logic ok);
        logic [7:0] s;
        logic a0, a1, a2;
        start();
        byte_io({adr, 1'b0}, s, a0);
        byte_io(ofs, s, a1);
        byte_io(d, s, a2);
        ok = !(a0 | a1 | a2);
        if (do_stop) begin
            stop();
        end
    endtask
    task automatic read(input logic [7:0] ofs, output logic [7:0] d);
        logic [7:0] s;
        logic a;
        start();
        byte_io({DRS_I2C_DEV_ADDR, 1'b0}, s, a);
        byte_io(ofs, s, a);
        start();
        byte_io({DRS_I2C_DEV_ADDR, 1'b1}, s, a);
        byte_io(8'hff, d, a);
        stop();
    endtask
endmodule // drs_host_model

// File: drs_pkg.sv
// constants shared by the display rail enable sequencer
package drs_pkg;
    // enable register location and fields
    localparam logic [7:0] DRS_RAIL_ENABLE_CONTROL_OFS = 8'h05;
    localparam int DRS_BOOST_EN_BIT = 0;
    localparam int DRS_NEG_EN_BIT = 1;
    localparam int DRS_POS_EN_BIT = 2;
    localparam int DRS_POS_HIZ_BIT = 6;
    localparam logic [7:0] DRS_RAIL_ENABLE_CONTROL_RST = 8'h07;
    // read value of every unmapped register address
    localparam logic [7:0] DRS_UNMAPPED_RDATA = 8'h00;
    // 7-bit target address, arbitrary value
    localparam logic [6:0] DRS_I2C_DEV_ADDR = 7'h29;
    // timing
    localparam longint DRS_MCLK_HZ = 40000000;
    localparam longint DRS_NEG_DELAY_US = 2000;
    localparam int DRS_NEG_DELAY_CYC =
        int'((DRS_NEG_DELAY_US * DRS_MCLK_HZ) / 1000000);
    // i2c slave states
    typedef enum logic [2:0] {
        DRS_ST_IDLE = 3'b000,
        DRS_ST_ADDR = 3'b001,
        DRS_ST_REG = 3'b010,
        DRS_ST_DATA = 3'b011,
        DRS_ST_TX = 3'b100,
        DRS_ST_MACK = 3'b101
    } drs_i2c_state_t;
endpackage

// File: drs_sequencer.sv
// display rail enable sequencer with i2c enable register
`timescale 1ns/1ps
module drs_sequencer
    import drs_pkg::*;
#(
    parameter int NEG_DELAY_CYCLES = drs_pkg::DRS_NEG_DELAY_CYC,
    parameter logic [6:0] DEV_ADDR = drs_pkg::DRS_I2C_DEV_ADDR
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic i2c_scl,
    input wire logic i2c_sda_in,
    output logic i2c_sda_out,
    output logic i2c_sda_oe,
    input wire logic positive_rail_enable_pin,
    input wire logic negative_rail_enable_pin,
    input wire logic boost_softstart_done,
    output logic boost_output_stage_en,
    output logic positive_output_rail_en,
    output logic negative_output_rail_en,
    output logic positive_output_rail_pulldown_en
);
    import drs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // bus line synchronisers and condition detection
    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic scl_d_r;
    logic sda_d_r;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_sync_r <= {scl_sync_r[0], i2c_scl};
            sda_sync_r <= {sda_sync_r[0], i2c_sda_in};
            scl_d_r <= scl_sync_r[1];
            sda_d_r <= sda_sync_r[1];
        end
    end

    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    assign scl_s = scl_sync_r[1];
    assign sda_s = sda_sync_r[1];
    assign scl_rise = scl_s && !scl_d_r;
    assign scl_fall = !scl_s && scl_d_r;
    // sda moving while scl stays high marks start or stop
    assign start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
    assign stop_det = scl_s && scl_d_r && !sda_d_r && sda_s;

    ////////////////////////////////////////////////////////////////////////
    // i2c slave
    drs_i2c_state_t state_r;
    logic [3:0] cnt_r;
    logic ack_ph_r;
    logic rw_r;
    logic nack_r;
    logic [7:0] rx_sh_r;
    logic [7:0] tx_sh_r;
    logic [7:0] ptr_r;
    logic [7:0] shadow_r;
    logic pend_r;
    logic sda_oe_r;
    logic sda_out_r;
    logic [7:0] ctl_r;
    logic [7:0] rd_data;

    assign rd_data = (ptr_r == DRS_RAIL_ENABLE_CONTROL_OFS) ?
        ctl_r : DRS_UNMAPPED_RDATA;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_r <= DRS_ST_IDLE;
            cnt_r <= 4'h0;
            ack_ph_r <= 1'b0;
            rw_r <= 1'b0;
            nack_r <= 1'b0;
            rx_sh_r <= 8'h00;
            tx_sh_r <= 8'h00;
            ptr_r <= 8'h00;
            shadow_r <= 8'h00;
            pend_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (start_det) begin
            state_r <= DRS_ST_ADDR;
            cnt_r <= 4'h0;
            ack_ph_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (stop_det) begin
            state_r <= DRS_ST_IDLE;
            ack_ph_r <= 1'b0;
            sda_oe_r <= 1'b0;
            pend_r <= 1'b0;
        end else if (scl_rise) begin
            if (state_r == DRS_ST_MACK) begin
                nack_r <= sda_s;
            end else if (state_r != DRS_ST_TX && state_r != DRS_ST_IDLE
                         && !ack_ph_r && cnt_r != 4'h8) begin
                rx_sh_r <= {rx_sh_r[6:0], sda_s};
                cnt_r <= cnt_r + 4'h1;
            end
        end else if (scl_fall) begin
            unique case (state_r)
                DRS_ST_IDLE: begin
                    sda_oe_r <= 1'b0;
                end
                DRS_ST_ADDR: begin
                    if (ack_ph_r) begin
                        ack_ph_r <= 1'b0;
                        cnt_r <= 4'h0;
                        if (rw_r) begin
                            state_r <= DRS_ST_TX;
                            tx_sh_r <= rd_data;
                            sda_oe_r <= !rd_data[7];
                        end else begin
                            state_r <= DRS_ST_REG;
                            sda_oe_r <= 1'b0;
                        end
                    end else if (cnt_r == 4'h8) begin
                        if (rx_sh_r[7:1] == DEV_ADDR) begin
                            ack_ph_r <= 1'b1;
                            sda_oe_r <= 1'b1;
                            rw_r <= rx_sh_r[0];
                        end else begin
                            state_r <= DRS_ST_IDLE;
                        end
                    end
                end
                DRS_ST_REG, DRS_ST_DATA: begin
                    if (ack_ph_r) begin
                        ack_ph_r <= 1'b0;
                        cnt_r <= 4'h0;
                        sda_oe_r <= 1'b0;
                        state_r <= DRS_ST_DATA;
                    end else if (cnt_r == 4'h8) begin
                        ack_ph_r <= 1'b1;
                        sda_oe_r <= 1'b1;
                        if (state_r == DRS_ST_REG) begin
                            ptr_r <= rx_sh_r;
                        end else if (ptr_r ==
                                     DRS_RAIL_ENABLE_CONTROL_OFS) begin
                            shadow_r <= rx_sh_r;
                            pend_r <= 1'b1;
                        end
                    end
                end
                DRS_ST_TX: begin
                    if (cnt_r == 4'h7) begin
                        sda_oe_r <= 1'b0;
                        state_r <= DRS_ST_MACK;
                    end else begin
                        tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                        sda_oe_r <= !tx_sh_r[6];
                        cnt_r <= cnt_r + 4'h1;
                    end
                end
                DRS_ST_MACK: begin
                    cnt_r <= 4'h0;
                    if (nack_r) begin
                        state_r <= DRS_ST_IDLE;
                    end else begin
                        state_r <= DRS_ST_TX;
                        tx_sh_r <= rd_data;
                        sda_oe_r <= !rd_data[7];
                    end
                end
                default: begin
                    state_r <= DRS_ST_IDLE;
                    sda_oe_r <= 1'b0;
                end
            endcase
        end
    end

    // open drain: only ever pulls low
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            sda_out_r <= 1'b0;
        end else begin
            sda_out_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // enable register
    // commit at stop
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ctl_r <= DRS_RAIL_ENABLE_CONTROL_RST;
        end else if (stop_det && pend_r) begin
            ctl_r <= shadow_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // rail sequencing
    logic boost_cond;
    logic pos_cond;
    logic neg_cond;
    logic neg_delay_done;

    assign boost_cond = (positive_rail_enable_pin ||
                         negative_rail_enable_pin) &&
                        ctl_r[DRS_BOOST_EN_BIT];
    assign pos_cond = positive_rail_enable_pin && ctl_r[DRS_POS_EN_BIT] &&
                      boost_cond && boost_softstart_done;
    assign neg_cond = negative_rail_enable_pin && ctl_r[DRS_NEG_EN_BIT] &&
                      boost_cond && boost_softstart_done;

    drs_delay_timer #(
        .CYCLES(NEG_DELAY_CYCLES)
    ) u_neg_delay (
        .mclk(mclk),
        .rstn(rstn),
        .run(neg_cond),
        .done(neg_delay_done)
    );

    logic boost_r;
    logic pos_r;
    logic neg_r;
    logic pulldown_r;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            boost_r <= 1'b0;
            pos_r <= 1'b0;
            neg_r <= 1'b0;
        end else begin
            boost_r <= boost_cond;
            pos_r <= pos_cond;
            neg_r <= neg_cond && neg_delay_done;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pulldown_r <= 1'b1;
        end else begin
            pulldown_r <= !pos_cond && !ctl_r[DRS_POS_HIZ_BIT];
        end
    end

    assign i2c_sda_out = sda_out_r;
    assign i2c_sda_oe = sda_oe_r;
    assign boost_output_stage_en = boost_r;
    assign positive_output_rail_en = pos_r;
    assign negative_output_rail_en = neg_r;
    assign positive_output_rail_pulldown_en = pulldown_r;
endmodule // drs_sequencer

// File: drs_sequencer_monitor.sv
// rail sequencing checker bound to the sequencer ports
`timescale 1ns/1ps
module drs_seq_monitor #(
    parameter int NEG_DELAY_CYCLES = 20
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic positive_rail_enable_pin,
    input wire logic negative_rail_enable_pin,
    input wire logic boost_softstart_done,
    input wire logic boost_output_stage_en,
    input wire logic positive_output_rail_en,
    input wire logic negative_output_rail_en,
    input wire logic positive_output_rail_pulldown_en
);
    wire pp = positive_rail_enable_pin;
    wire np = negative_rail_enable_pin;
    wire ssd = boost_softstart_done;
    wire bst = boost_output_stage_en;
    wire pos = positive_output_rail_en;
    wire neg = negative_output_rail_en;
    int run_r;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // register gating can only shorten the real run, never lengthen it
    always_ff @(posedge mclk) begin
        if (!rstn || !(np && ssd)) begin
            run_r <= 0;
        end else if (run_r < 1000) begin
            run_r <= run_r + 1;
        end
    end
    a_boost_pin_gate: assert property (bst |-> $past(pp || np))
        else $error("boost on without an enable pin");
    a_pos_cause: assert property (pos |-> $past(pp && ssd))
        else $error("positive rail on without pin and soft-start");
    a_neg_cause: assert property (neg |-> $past(np && ssd))
        else $error("negative rail on without pin and soft-start");
    a_neg_delay: assert property (
        $rose(neg) |-> run_r >= NEG_DELAY_CYCLES)
        else $error("negative rail started before its delay");
    a_pins_low_off: assert property (
        !pp && !np |=> !bst && !pos && !neg)
        else $error("rails or boost on with both pins low");
    a_tied_fall: assert property (
        (pp && np) ##1 (!pp && !np) |=> !pos && !neg)
        else $error("rails did not stop together");
    a_pos_pin_off: assert property (!pp |=> !pos)
        else $error("positive rail on with its pin low");
    a_neg_pin_off: assert property (!np |=> !neg)
        else $error("negative rail on with its pin low");
    a_pulldown_off: assert property (
        pos |-> !positive_output_rail_pulldown_en)
        else $error("pull-down engaged while positive rail on");
    c_neg_up: cover property ($rose(neg));
    c_pos_up: cover property ($rose(pos));
    c_float: cover property (!pos && !positive_output_rail_pulldown_en);
endmodule // drs_seq_monitor
bind drs_sequencer drs_seq_monitor #(
    .NEG_DELAY_CYCLES(NEG_DELAY_CYCLES)
) mon_i (
    .mclk(mclk),
    .rstn(rstn),
    .positive_rail_enable_pin(positive_rail_enable_pin),
    .negative_rail_enable_pin(negative_rail_enable_pin),
    .boost_softstart_done(boost_softstart_done),
    .boost_output_stage_en(boost_output_stage_en),
    .positive_output_rail_en(positive_output_rail_en),
    .negative_output_rail_en(negative_output_rail_en),
    .positive_output_rail_pulldown_en(positive_output_rail_pulldown_en)
);

// File: tb_top.sv
// self-checking bench for the display rail sequencer
`timescale 1ns/1ps
module tb_top;
    import drs_pkg::*;
    localparam int ND = 20;
    localparam logic [7:0] OFS = DRS_RAIL_ENABLE_CONTROL_OFS;
    localparam logic [6:0] ADR = DRS_I2C_DEV_ADDR;
    logic mclk, rstn, pp, np, ssd, scl, hlow, oe, so, bst, pos, neg, pd, ok;
    logic [7:0] rd;
    // device pulls low only with its enable set and its data at zero
    wire sda = !(hlow || (oe && !so));
    int errors = 0;
    int tests_run = 0;
    int cyc = 0;
    drs_sequencer #(.NEG_DELAY_CYCLES(ND)) drs_sequencer_i (
        .mclk(mclk), .rstn(rstn), .i2c_scl(scl), .i2c_sda_in(sda),
        .i2c_sda_out(so), .i2c_sda_oe(oe),
        .positive_rail_enable_pin(pp), .negative_rail_enable_pin(np),
        .boost_softstart_done(ssd), .boost_output_stage_en(bst),
        .positive_output_rail_en(pos), .negative_output_rail_en(neg),
        .positive_output_rail_pulldown_en(pd));
    drs_host_model drs_host_model_i (
        .mclk(mclk), .sda_wire(sda), .scl(scl), .sda_low(hlow));
    task automatic conclude;
        if (errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic rails(input logic [2:0] e);
        chk("rails", 8'(e), 8'({bst, pos, neg}));
    endtask
    // lead: edges already passed with the start condition high
    task automatic negdly(input int lead);
        wait_n(ND - lead);
        chk("neg_early", 8'h00, 8'(neg));
        wait_n(1);
        chk("neg_late", 8'h01, 8'(neg));
    endtask
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errors++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        {rstn, pp, np, ssd} = 4'h0;
        wait_n(4);
        rstn = 1'b1;
        wait_n(4);
        rails(3'b000);
        chk("pulldown", 8'h01, 8'(pd));
        drs_host_model_i.read(OFS, rd);
        chk("ctl_reset", DRS_RAIL_ENABLE_CONTROL_RST, rd);
        drs_host_model_i.read(8'h10, rd);
        chk("unmapped", DRS_UNMAPPED_RDATA, rd);
        {pp, np} = 2'b11;
        wait_n(ND + 10);
        rails(3'b100);
        ssd = 1'b1;
        wait_n(3);
        rails(3'b110);
        negdly(3);
        {pp, np} = 2'b00;
        wait_n(2);
        rails(3'b000);
        pp = 1'b1;
        wait_n(3);
        rails(3'b110);
        np = 1'b1;
        wait_n(ND / 2);
        np = 1'b0;
        wait_n(1);
        np = 1'b1;
        negdly(0);
        drs_host_model_i.write(ADR, OFS, 8'h03, 1'b0, ok);
        chk("ack", 8'h01, 8'(ok));
        rails(3'b111);
        drs_host_model_i.stop();
        wait_n(2);
        rails(3'b101);
        drs_host_model_i.write(ADR, OFS, 8'h01, 1'b1, ok);
        wait_n(2);
        rails(3'b100);
        drs_host_model_i.write(ADR, OFS, 8'h07, 1'b1, ok);
        wait_n(2);
        rails(3'b110);
        // commit edge plus the stop tail and the two waits above
        negdly(5);
        drs_host_model_i.write(ADR, OFS, 8'h47, 1'b1, ok);
        pp = 1'b0;
        wait_n(3);
        chk("pulldown", 8'h00, 8'(pd));
        rails(3'b101);
        drs_host_model_i.read(OFS, rd);
        chk("ctl_rb", 8'h47, rd);
        pp = 1'b1;
        drs_host_model_i.write(ADR, OFS, 8'h46, 1'b1, ok);
        wait_n(2);
        rails(3'b000);
        drs_host_model_i.write(ADR ^ 7'h01, OFS, 8'h07, 1'b1, ok);
        chk("nack", 8'h00, 8'(ok));
        drs_host_model_i.read(OFS, rd);
        chk("ctl_kept", 8'h46, rd);
        // mid-run reset brings back the enable defaults
        rstn = 1'b0;
        wait_n(2);
        rstn = 1'b1;
        wait_n(4);
        rails(3'b110);
        drs_host_model_i.read(OFS, rd);
        chk("ctl_rst2", DRS_RAIL_ENABLE_CONTROL_RST, rd);
        rails(3'b111);
        conclude();
    end
endmodule // tb_top
